//--- design/wos_pkg.sv
package wos_pkg;
    // ==========================================================
    // Frame and field layout
    localparam int FRAME_W = 16;
    localparam int WIPER_W = 10;
    localparam int CMD_LSB = 10;
    localparam int CMD_MSB = 13;
    localparam int IDX_W = 5;
    localparam int SLOTS = 20;
    localparam logic [WIPER_W-1:0] WIPER_MID = 10'h200;

    // ==========================================================
    // Command codes
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_WIPER = 4'h1;
    localparam logic [3:0] CMD_RD_WIPER = 4'h2;
    localparam logic [3:0] CMD_STORE = 4'h3;
    localparam logic [3:0] CMD_RELOAD = 4'h4;
    localparam logic [3:0] CMD_RD_OTP = 4'h5;
    localparam logic [3:0] CMD_WR_CTRL = 4'h6;
    localparam logic [3:0] CMD_RD_CTRL = 4'h7;

    // ==========================================================
    // Control register bits and readback indices
    localparam int CTRL_W = 4;
    localparam int CTRL_PE = 0;
    localparam int CTRL_WWU = 1;
    localparam int CTRL_CAL = 2;
    localparam int CTRL_OK = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    localparam logic [IDX_W-1:0] IDX_THERM_LO = 5'h14;
    localparam logic [IDX_W-1:0] IDX_THERM_HI = 5'h15;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int PROG_TIME_US = 8000;
    localparam int STORE_TIME_US = 6000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
endpackage : wos_pkg

//--- design/wos_otp_if.sv
`timescale 1ns/100ps
interface wos_otp_if;
    import wos_pkg::*;
    logic wr_en;
    logic [WIPER_W-1:0] wr_data;
    logic [IDX_W-1:0] rd_idx;
    logic [WIPER_W-1:0] rd_data;
    logic [WIPER_W-1:0] last_data;
    logic [IDX_W-1:0] used;
    modport ctl (output wr_en, wr_data, rd_idx, input rd_data, last_data, used);
    modport mem (input wr_en, wr_data, rd_idx, output rd_data, last_data, used);
endinterface : wos_otp_if

//--- design/wos_otp_array.sv
`timescale 1ns/100ps
module wos_otp_array
    import wos_pkg::*;
#(
    parameter int SLOT_N = SLOTS
)(
    input wire logic ref_clk,
    input wire logic blank,
    wos_otp_if.mem otp
);
    // ==========================================================
    // Storage
    typedef struct packed {
        logic [IDX_W-1:0] used;
    } wos_arr_t;

    wos_arr_t r;
    wos_arr_t next_r;
    logic [WIPER_W-1:0] slot [SLOT_N];
    logic [WIPER_W-1:0] therm_lo;
    logic [WIPER_W-1:0] therm_hi;

    generate
        if (SLOT_N < 1 || SLOT_N > 2 * WIPER_W)
        begin : g_bad
            $error("SLOT_N outside what the usage words can show");
        end
    endgenerate

    // Count survives rst: only a blank-part init clears it
    always_comb
    begin
        next_r = r;
        if (otp.wr_en && r.used < IDX_W'(SLOT_N))
        begin
            next_r.used = r.used + 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (blank)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Each slot written once, in order
    always_ff @(posedge ref_clk)
    begin
        if (otp.wr_en && r.used < IDX_W'(SLOT_N))
        begin
            slot[r.used] <= otp.wr_data;
        end
    end

    // ==========================================================
    // Readback
    generate
        for (genvar i = 0; i < WIPER_W; i++)
        begin : g_therm
            assign therm_lo[i] = (r.used > IDX_W'(i));
            assign therm_hi[i] = (r.used > IDX_W'(i + WIPER_W));
        end
    endgenerate

    always_comb
    begin
        if (otp.rd_idx < IDX_W'(SLOT_N))
        begin
            otp.rd_data = slot[otp.rd_idx];
        end
        else if (otp.rd_idx == IDX_THERM_LO)
        begin
            otp.rd_data = therm_lo;
        end
        else if (otp.rd_idx == IDX_THERM_HI)
        begin
            otp.rd_data = therm_hi;
        end
        else
        begin
            otp.rd_data = '0;
        end
    end

    assign otp.last_data = (r.used == '0) ? WIPER_MID : slot[IDX_W'(r.used - 1'b1)];
    assign otp.used = r.used;

    // ==========================================================
    // Checks
    property p_once_per_store;
        @(posedge ref_clk) disable iff (blank)
        otp.wr_en && r.used < IDX_W'(SLOT_N) |=> r.used == $past(r.used) + 1'b1;
    endproperty
    a_once_per_store: assert property (p_once_per_store)
        else $error("slot count did not advance on a store");

    property p_full_holds;
        @(posedge ref_clk) disable iff (blank)
        r.used == IDX_W'(SLOT_N) |=> r.used == IDX_W'(SLOT_N);
    endproperty
    a_full_holds: assert property (p_full_holds)
        else $error("slot count moved past full");
endmodule : wos_otp_array

//--- design/wos_top.sv
`timescale 1ns/100ps
// What this block does
// - Twenty write-once slots; newest restores wiper.
// - Verify each store; report in success flag.
// - Lock shifting and decoding during programming.
// - Ready pin low while programming runs.
// - Blank memory restores midscale wiper.
// - Wiper write and store locked at power-up.
// - Unlock bit clear ignores wiper writes.
// - Command 4 or reset pin reloads wiper.
// - Command 1 loads data into wiper.
// - Command 3 stores wiper into next slot.
// - Control word 0x1803 sets both unlocks.
// - Word 0x0500 loads wiper code 0x100.
// - Command 2 returns wiper next frame.
// - Command 7 returns control bits next frame.
// - Command 5 indices 0x00-0x13 read slots.
// - Indices 0x14, 0x15 give thermometer usage.
// - Sixteen-bit MSB-first frame decoded on rising select.
// - Four control bits, all reset zero.
// - Reset reloads wiper and clears control.
module wos_top
    import wos_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES,
    parameter int STORE_CYC = STORE_CYCLES
)(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic blank_otp,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    input wire logic reset_n,
    output logic sdo_o,
    output logic sdo_oe,
    output logic rdy,
    output logic [WIPER_W-1:0] wiper_setting_register,
    output logic otp_program_enable_bit,
    output logic wiper_write_unlock_bit,
    output logic calibration_enable_bit,
    output logic program_success_flag
);
    // ==========================================================
    // State
    localparam int TW = $clog2(PROG_CYC + 1);

    typedef enum logic {
        ST_IDLE,
        ST_PROG
    } wos_st_t;

    typedef struct packed {
        wos_st_t st;
        logic [2:0] s_sclk;
        logic [2:0] s_sync;
        logic [1:0] s_din;
        logic [2:0] s_rst;
        logic [FRAME_W-1:0] rx;
        logic [FRAME_W-1:0] tx;
        logic [FRAME_W-1:0] txsh;
        logic [3:0] cnt;
        logic got;
        logic [WIPER_W-1:0] wiper;
        logic [CTRL_W-1:0] ctrl;
        logic [TW-1:0] timer;
        logic wr_en;
        logic [WIPER_W-1:0] wr_data;
        logic rdy;
        logic sdo_oe;
        logic sdo_lo;
        logic boot;
    } wos_state_t;

    wos_state_t r;
    wos_state_t next_r;
    wos_otp_if otp ();

    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic pin_rise;
    logic dec;
    logic reload;
    logic [3:0] cmd;
    logic [WIPER_W-1:0] data;
    logic can_store;

    generate
        if (STORE_CYC < 1 || STORE_CYC >= PROG_CYC - 1)
        begin : g_bad
            $error("STORE_CYC must lie inside the programming interval");
        end
    endgenerate

    wos_otp_array #(
        .SLOT_N(SLOTS)
    ) u_array (
        .ref_clk(ref_clk),
        .blank(blank_otp),
        .otp(otp.mem)
    );

    assign otp.wr_en = r.wr_en;
    assign otp.wr_data = r.wr_data;
    assign otp.rd_idx = r.rx[IDX_W-1:0];

    // ==========================================================
    // Pin edges, all from second and third sync stages
    assign sclk_fall = r.s_sclk[2] & ~r.s_sclk[1];
    assign sync_fall = r.s_sync[2] & ~r.s_sync[1];
    assign sync_rise = ~r.s_sync[2] & r.s_sync[1];
    assign pin_rise = ~r.s_rst[2] & r.s_rst[1];

    assign cmd = r.rx[CMD_MSB:CMD_LSB];
    assign data = r.rx[WIPER_W-1:0];
    // Only whole multiples of 16 bits are decoded
    assign dec = sync_rise && r.cnt == '0 && r.got && r.st == ST_IDLE;
    assign reload = (dec && cmd == CMD_RELOAD) || pin_rise || r.boot;
    assign can_store = r.ctrl[CTRL_PE] && otp.used < IDX_W'(SLOTS);

    // ==========================================================
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.s_sclk = {r.s_sclk[1:0], sclk};
        next_r.s_sync = {r.s_sync[1:0], sync_n};
        next_r.s_din = {r.s_din[0], din};
        next_r.s_rst = {r.s_rst[1:0], reset_n};
        next_r.wr_en = 1'b0;
        next_r.sdo_lo = 1'b0;

        // Shifter frozen while programming
        if (!r.s_sync[1] && sclk_fall && r.st == ST_IDLE)
        begin
            next_r.rx = {r.rx[FRAME_W-2:0], r.s_din[1]};
            next_r.txsh = {r.txsh[FRAME_W-2:0], 1'b0};
            next_r.cnt = r.cnt + 1'b1;
            next_r.got = 1'b1;
        end
        if (sync_fall)
        begin
            next_r.txsh = r.tx;
            next_r.cnt = '0;
            next_r.got = 1'b0;
        end

        if (dec)
        begin
            next_r.tx = r.rx;
            unique case (cmd)
                CMD_WR_WIPER:
                begin
                    if (r.ctrl[CTRL_WWU])
                    begin
                        next_r.wiper = data;
                    end
                end
                CMD_RD_WIPER:
                begin
                    next_r.tx = {{(FRAME_W - WIPER_W){1'b0}}, r.wiper};
                end
                CMD_STORE:
                begin
                    next_r.ctrl[CTRL_OK] = 1'b0;
                    if (can_store)
                    begin
                        next_r.st = ST_PROG;
                        next_r.timer = '0;
                        next_r.wr_data = r.wiper;
                        next_r.rdy = 1'b0;
                    end
                end
                CMD_RD_OTP:
                begin
                    next_r.tx = {{(FRAME_W - WIPER_W){1'b0}}, otp.rd_data};
                end
                CMD_WR_CTRL:
                begin
                    // Success flag is hardware-owned, writes leave it
                    next_r.ctrl[CTRL_CAL:CTRL_PE] = data[CTRL_CAL:CTRL_PE];
                end
                CMD_RD_CTRL:
                begin
                    next_r.tx = {{(FRAME_W - CTRL_W){1'b0}}, r.ctrl};
                end
                default:
                begin
                end
            endcase
        end

        if (reload)
        begin
            next_r.wiper = otp.last_data;
            next_r.ctrl = CTRL_RESET;
            next_r.boot = 1'b0;
        end

        // Programming runs to the end even across a pin reset;
        // the verify result is written last so it wins over a clear
        if (r.st == ST_PROG)
        begin
            next_r.timer = r.timer + 1'b1;
            if (r.timer == TW'(STORE_CYC - 1))
            begin
                next_r.wr_en = 1'b1;
            end
            if (r.timer == TW'(PROG_CYC - 1))
            begin
                next_r.st = ST_IDLE;
                next_r.rdy = 1'b1;
                next_r.ctrl[CTRL_OK] = (otp.last_data == r.wr_data);
            end
        end

        // Open drain: pull low for a zero bit inside a frame
        next_r.sdo_oe = ~r.s_sync[1] & ~next_r.txsh[FRAME_W-1];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            r <= '0;
            r.wiper <= WIPER_MID;
            r.rdy <= 1'b1;
            r.boot <= 1'b1;
            r.s_sync <= '1;
            r.s_rst <= '1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs
    assign sdo_o = r.sdo_lo;
    assign sdo_oe = r.sdo_oe;
    assign rdy = r.rdy;
    assign wiper_setting_register = r.wiper;
    assign otp_program_enable_bit = r.ctrl[CTRL_PE];
    assign wiper_write_unlock_bit = r.ctrl[CTRL_WWU];
    assign calibration_enable_bit = r.ctrl[CTRL_CAL];
    assign program_success_flag = r.ctrl[CTRL_OK];

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_store_start;
        dec && cmd == CMD_STORE && can_store;
    endsequence

    sequence s_prog_end;
        r.st == ST_PROG && r.timer == TW'(PROG_CYC - 1);
    endsequence

    property p_wiper_locked;
        dec && cmd == CMD_WR_WIPER && !r.ctrl[CTRL_WWU] && !pin_rise |=> $stable(r.wiper);
    endproperty
    a_wiper_locked: assert property (p_wiper_locked)
        else $error("wiper changed while write locked");

    property p_wiper_write;
        dec && cmd == CMD_WR_WIPER && r.ctrl[CTRL_WWU] && !pin_rise && !r.boot
            |=> r.wiper == $past(data);
    endproperty
    a_wiper_write: assert property (p_wiper_write)
        else $error("wiper write did not load data");

    property p_lock_busy;
        s_store_start |=> !rdy [*8] ##0 (r.st == ST_PROG && $stable(r.tx));
    endproperty
    a_lock_busy: assert property (p_lock_busy)
        else $error("programming did not hold ready low and lock");

    property p_frozen;
        r.st == ST_PROG && !pin_rise |=> $stable(r.rx) && $stable(r.ctrl[CTRL_CAL:CTRL_PE]);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("state changed during programming");

    property p_ready_pin;
        $rose(rdy) |-> $past(r.st) == ST_PROG && $past(r.timer) == TW'(PROG_CYC - 1);
    endproperty
    a_ready_pin: assert property (p_ready_pin)
        else $error("ready rose at wrong moment");

    property p_store_moment;
        otp.wr_en |-> r.st == ST_PROG && r.timer == TW'(STORE_CYC);
    endproperty
    a_store_moment: assert property (p_store_moment)
        else $error("slot write at wrong time");

    property p_verify;
        s_prog_end |=> program_success_flag == (otp.last_data == r.wr_data);
    endproperty
    a_verify: assert property (p_verify)
        else $error("success flag disagrees with verify");

    property p_refused;
        dec && cmd == CMD_STORE && !can_store |=> !program_success_flag && r.st == ST_IDLE
            && $stable(otp.used);
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused store changed state");

    property p_rd_wiper;
        dec && cmd == CMD_RD_WIPER |=> r.tx == {6'h00, $past(r.wiper)};
    endproperty
    a_rd_wiper: assert property (p_rd_wiper)
        else $error("wiper readback word wrong");

    property p_rd_ctrl;
        dec && cmd == CMD_RD_CTRL |=> r.tx == {12'h000, $past(r.ctrl)};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control readback word wrong");

    property p_echo;
        dec && cmd == CMD_NOP |=> r.tx == $past(r.rx);
    endproperty
    a_echo: assert property (p_echo)
        else $error("previous frame not echoed");

    property p_reload;
        reload && r.st == ST_IDLE |=> r.wiper == $past(otp.last_data) && r.ctrl == CTRL_RESET;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload did not restore wiper and control");

    property p_powerup;
        $past(rst) |-> r.ctrl == CTRL_RESET ##1 r.wiper == $past(otp.last_data);
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("power-up state wrong");
endmodule : wos_top

//--- sim/wos_host.sv
`timescale 1ns/100ps
module wos_host
(
    output logic sclk,
    output logic sync_n,
    output logic din,
    input wire logic sdo
);
    localparam real HALF = 62.5;

    initial
    begin
        sclk = 1'b0;
        sync_n = 1'b1;
        din = 1'b1;
    end

    // ==========================================================
    // Frame transfer
    // Link clock stands still between frames; the phase is locked to ref_clk edges
    // Half periods land on ref_clk edges; non-blocking keeps pins off the race
    task automatic send(input logic [15:0] word, output logic [15:0] resp);
        sync_n <= 1'b0;
        #(HALF);
        for (int i = 15; i >= 0; i--)
        begin
            sclk <= 1'b1;
            resp[i] = sdo;
            din <= word[i];
            #(HALF);
            sclk <= 1'b0;
            #(HALF);
        end
        sync_n <= 1'b1;
        // Inverted idle bit so a stale value cannot pass for a real one
        din <= ~word[0];
        #(2.0 * HALF);
    endtask : send
endmodule : wos_host

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    import wos_pkg::*;
    localparam int PROG_T = 1000;
    localparam int STORE_T = 600;
    logic ref_clk, rst, blank_otp, reset_n, sclk, sync_n, din;
    logic sdo_o, sdo_oe, sdo_wire, rdy, pe, wwu, cal, ok;
    logic [WIPER_W-1:0] wiper;
    logic [15:0] resp;
    int num_errors, cmp_count;

    // Open-drain data line with pull-up
    assign sdo_wire = sdo_oe ? sdo_o : 1'b1;

    wos_top #(.PROG_CYC(PROG_T), .STORE_CYC(STORE_T)) DUT (.ref_clk(ref_clk), .rst(rst),
        .blank_otp(blank_otp), .sclk(sclk), .sync_n(sync_n), .din(din), .reset_n(reset_n),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .rdy(rdy), .wiper_setting_register(wiper),
        .otp_program_enable_bit(pe), .wiper_write_unlock_bit(wwu),
        .calibration_enable_bit(cal), .program_success_flag(ok));

    wos_host host (.sclk(sclk), .sync_n(sync_n), .din(din), .sdo(sdo_wire));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Shared helpers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] ctrl_w();
        return {12'h000, ok, cal, wwu, pe};
    endfunction : ctrl_w

    function automatic logic [15:0] wip_w();
        return {6'h00, wiper};
    endfunction : wip_w

    task automatic xfer(input logic [15:0] word);
        host.send(word, resp);
    endtask : xfer

    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 3000)
        begin
            // Sampled mid-cycle, where the ready flop has settled
            @(negedge ref_clk);
            n++;
        end
        if (rdy !== 1'b1)
        begin
            num_errors++;
            $display("mismatch at %0t: seen 0x%h expected 0x1", $time, rdy);
            tally_and_finish();
        end
    endtask : wait_rdy

    task automatic t_power(input logic blank, input logic [15:0] exp_wiper);
        @(posedge ref_clk);
        rst <= 1'b1;
        blank_otp <= blank;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        blank_otp <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(wip_w(), exp_wiper);
        check(ctrl_w(), 16'h0000);
        check({15'h0000, rdy}, 16'h0001);
        $display("test power done");
    endtask : t_power

    // ==========================================================
    // Scenarios
    task automatic t_locked();
        xfer(16'h0500);
        check(wip_w(), 16'h0200);
        xfer(16'h0C00);
        check({15'h0000, rdy}, 16'h0001);
        xfer(16'h1414);
        check(resp, 16'h0C00);
        xfer(16'h0000);
        check(resp, 16'h0000);
        $display("test locked done");
    endtask : t_locked

    task automatic t_write_store();
        xfer(16'h1803);
        check(ctrl_w(), 16'h0003);
        xfer(16'h0500);
        check(resp, 16'h1803);
        check(wip_w(), 16'h0100);
        xfer(16'h0800);
        xfer(16'h0C00);
        check(resp, 16'h0100);
        check({15'h0000, rdy}, 16'h0000);
        // Sent while programming; must be lost
        xfer(16'h04FF);
        wait_rdy();
        check(wip_w(), 16'h0100);
        check(ctrl_w(), 16'h000B);
        xfer(16'h1C00);
        xfer(16'h0000);
        check(resp, 16'h000B);
        $display("test write_store done");
    endtask : t_write_store

    task automatic t_readback();
        xfer(16'h06AB);
        xfer(16'h0C00);
        wait_rdy();
        xfer(16'h1400);
        xfer(16'h1401);
        check(resp, 16'h0100);
        xfer(16'h1414);
        check(resp, 16'h02AB);
        xfer(16'h1415);
        check(resp, 16'h0003);
        xfer(16'h0000);
        check(resp, 16'h0000);
        $display("test readback done");
    endtask : t_readback

    task automatic t_fill();
        for (int k = 2; k < 20; k++)
        begin
            xfer(16'h0700 | 16'(k));
            xfer(16'h0C00);
            wait_rdy();
        end
        // All slots used: store refused
        xfer(16'h0C00);
        check({15'h0000, rdy}, 16'h0001);
        check(ctrl_w(), 16'h0003);
        xfer(16'h1415);
        xfer(16'h0000);
        check(resp, 16'h03FF);
        $display("test fill done");
    endtask : t_fill

    task automatic t_reload();
        xfer(16'h0455);
        check(wip_w(), 16'h0055);
        xfer(16'h1000);
        check(wip_w(), 16'h0313);
        check(ctrl_w(), 16'h0000);
        xfer(16'h0466);
        check(wip_w(), 16'h0313);
        // Success bit write must be dropped; calibration bit takes a one
        xfer(16'h180F);
        check(ctrl_w(), 16'h0007);
        xfer(16'h0466);
        check(wip_w(), 16'h0066);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check(wip_w(), 16'h0313);
        check(ctrl_w(), 16'h0000);
        $display("test reload done");
    endtask : t_reload

    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        blank_otp = 1'b1;
        reset_n = 1'b1;
        num_errors = 0;
        cmp_count = 0;
        t_power(1'b1, 16'h0200);
        t_locked();
        t_write_store();
        t_readback();
        t_fill();
        t_reload();
        // Power cycle keeps the stored slots
        t_power(1'b0, 16'h0313);
        tally_and_finish();
    end
endmodule : testbench
